//--- core/mde_defs.vh
// Constants shared by the message digest engine
`ifndef MDE_DEFS_VH
`define MDE_DEFS_VH

// ----------------------------------------------------------------
// Block timing, in clock cycles per 512-bit block
// ----------------------------------------------------------------
`define MDE_SHA1_BLOCK_CYCLES 7'h42
`define MDE_MD5_BLOCK_CYCLES  7'h32
`define MDE_SHA1_ROUND_PAIRS  7'h28
`define MDE_MD5_ROUND_PAIRS   7'h20

// ----------------------------------------------------------------
// Input buffer depth and last digest word index
// ----------------------------------------------------------------
`define MDE_FIFO_DEPTH        5'h10
`define MDE_DIGEST_LAST_INDEX 3'h4

// ----------------------------------------------------------------
// Swap codes
// ----------------------------------------------------------------
`define MDE_SWAP_WORD 2'h0
`define MDE_SWAP_HALF 2'h1
`define MDE_SWAP_BYTE 2'h2
`define MDE_SWAP_BIT  2'h3

// ----------------------------------------------------------------
// Initial chaining value, word 0 in the top bits
// ----------------------------------------------------------------
`define MDE_IV {32'h6745_2301, 32'hefcd_ab89, 32'h98ba_dcfe, 32'h1032_5476, 32'hc3d2_e1f0}

// ----------------------------------------------------------------
// SHA-1 round constants
// ----------------------------------------------------------------
`define MDE_SHA1_K0 32'h5a82_7999
`define MDE_SHA1_K1 32'h6ed9_eba1
`define MDE_SHA1_K2 32'h8f1b_bcdc
`define MDE_SHA1_K3 32'hca62_c1d6

// ----------------------------------------------------------------
// MD5 sine constants and per-round shift amounts
// ----------------------------------------------------------------
`define MDE_MD5_K { \
	32'hd76a_a478, 32'he8c7_b756, 32'h2420_70db, 32'hc1bd_ceee, \
	32'hf57c_0faf, 32'h4787_c62a, 32'ha830_4613, 32'hfd46_9501, \
	32'h6980_98d8, 32'h8b44_f7af, 32'hffff_5bb1, 32'h895c_d7be, \
	32'h6b90_1122, 32'hfd98_7193, 32'ha679_438e, 32'h49b4_0821, \
	32'hf61e_2562, 32'hc040_b340, 32'h265e_5a51, 32'he9b6_c7aa, \
	32'hd62f_105d, 32'h0244_1453, 32'hd8a1_e681, 32'he7d3_fbc8, \
	32'h21e1_cde6, 32'hc337_07d6, 32'hf4d5_0d87, 32'h455a_14ed, \
	32'ha9e3_e905, 32'hfcef_a3f8, 32'h676f_02d9, 32'h8d2a_4c8a, \
	32'hfffa_3942, 32'h8771_f681, 32'h6d9d_6122, 32'hfde5_380c, \
	32'ha4be_ea44, 32'h4bde_cfa9, 32'hf6bb_4b60, 32'hbebf_bc70, \
	32'h289b_7ec6, 32'heaa1_27fa, 32'hd4ef_3085, 32'h0488_1d05, \
	32'hd9d4_d039, 32'he6db_99e5, 32'h1fa2_7cf8, 32'hc4ac_5665, \
	32'hf429_2244, 32'h432a_ff97, 32'hab94_23a7, 32'hfc93_a039, \
	32'h655b_59c3, 32'h8f0c_cc92, 32'hffef_f47d, 32'h8584_5dd1, \
	32'h6fa8_7e4f, 32'hfe2c_e6e0, 32'ha301_4314, 32'h4e08_11a1, \
	32'hf753_7e82, 32'hbd3a_f235, 32'h2ad7_d2bb, 32'heb86_d391}
`define MDE_MD5_S { \
	5'h07, 5'h0c, 5'h11, 5'h16, 5'h05, 5'h09, 5'h0e, 5'h14, \
	5'h04, 5'h0b, 5'h10, 5'h17, 5'h06, 5'h0a, 5'h0f, 5'h15}

`endif

//--- core/mde_top.v
// Message digest engine: SHA-1 / MD5 / two-pass keyed hash with 16-word input buffer
`timescale 1ns/1ps
`default_nettype none
`include "mde_defs.vh"
// How it works
// - SHA-1 or MD5 over long padded messages
// - Keyed mode hashes twice, outer pass restarts
// - SHA-1 block takes 66 clock cycles
// - MD5 block takes 50 clock cycles
// - Five digest words, software can reload them
// - Input word, half, byte or bit swap
// - Sixteen-word input buffer feeds the core
// - DMA request while buffer has free room
// - Ready, busy, DMA active, done status flags
// - One combined interrupt output
module mde_top (
	input  wire         clock,
	input  wire         arst_n,
	input  wire         algo_md5,
	input  wire         hmac_mode,
	input  wire [1:0]   swap_sel,
	input  wire         digest_init,
	input  wire [31:0]  data_in,
	input  wire         data_write,
	input  wire         last_block,
	input  wire         load_write,
	input  wire [2:0]   load_index,
	input  wire [31:0]  load_data,
	input  wire         dma_enable,
	input  wire         input_ready_irq_mask,
	input  wire         digest_done_irq_mask,
	input  wire         clear_input_ready,
	input  wire         clear_digest_done,
	output reg  [159:0] digest_words,
	output reg  [4:0]   fifo_level,
	output reg          input_ready_flag,
	output reg          busy,
	output reg          dma_active_flag,
	output reg          digest_done_flag,
	output reg          dma_req,
	output reg          irq
);
// ----------------------------------------------------------------
// Round helpers
// ----------------------------------------------------------------
localparam [2047:0] MD5_K = `MDE_MD5_K;
localparam [79:0]   MD5_S = `MDE_MD5_S;
function [31:0] rotl;
	input [31:0] x;
	input [4:0]  s;
	reg   [63:0] y;
	begin
		y = {x, x} << s;
		rotl = y[63:32];
	end
endfunction
function [31:0] word_at;
	input [511:0] v;
	input [3:0]   i;
	begin
		word_at = v[{i, 5'h00} +: 32];
	end
endfunction
// Schedule word for SHA-1 round t, kept in a 16-word sliding window
function [31:0] sha_w;
	input [511:0] v;
	input [6:0]   t;
	reg   [3:0]   i;
	begin
		i = t[3:0];
		if (t < 7'h10) begin
			sha_w = word_at(v, i);
		end else begin
			sha_w = rotl(word_at(v, i + 4'hd) ^ word_at(v, i + 4'h8)
				^ word_at(v, i + 4'h2) ^ word_at(v, i), 5'h01);
		end
	end
endfunction
function [3:0] md5_g;
	input [6:0] t;
	reg   [3:0] i;
	begin
		i = t[3:0];
		case (t[5:4])
			2'h0: md5_g = i;
			2'h1: md5_g = i * 4'h5 + 4'h1;
			2'h2: md5_g = i * 4'h3 + 4'h5;
			default: md5_g = i * 4'h7;
		endcase
	end
endfunction
// One round of either algorithm on the five-word working state
function [159:0] rnd;
	input [159:0] st;
	input [6:0]   t;
	input         md5;
	input [31:0]  wd;
	reg   [31:0]  a, b, c, d, e, f, k;
	reg   [3:0]   j;
	begin
		a = st[159:128];
		b = st[127:96];
		c = st[95:64];
		d = st[63:32];
		e = st[31:0];
		j = {t[5:4], t[1:0]};
		if (md5) begin
			case (t[5:4])
				2'h0: f = (b & c) | (~b & d);
				2'h1: f = (d & b) | (~d & c);
				2'h2: f = b ^ c ^ d;
				default: f = c ^ (b | ~d);
			endcase
			k = MD5_K[2047 - 32 * t[5:0] -: 32];
			rnd = {d, b + rotl(a + f + k + wd, MD5_S[79 - 5 * j -: 5]), b, c, e};
		end else begin
			if (t < 7'h14) begin
				f = (b & c) | (~b & d);
				k = `MDE_SHA1_K0;
			end else if (t < 7'h28) begin
				f = b ^ c ^ d;
				k = `MDE_SHA1_K1;
			end else if (t < 7'h3c) begin
				f = (b & c) | (b & d) | (c & d);
				k = `MDE_SHA1_K2;
			end else begin
				f = b ^ c ^ d;
				k = `MDE_SHA1_K3;
			end
			rnd = {rotl(a, 5'h05) + f + e + k + wd, a, rotl(b, 5'h1e), c, d};
		end
	end
endfunction
// ----------------------------------------------------------------
// Reset release
// ----------------------------------------------------------------
reg rst_meta_n;
reg rst_sync_n;
always @(posedge clock or negedge arst_n) begin
	if (!arst_n) begin
		rst_meta_n <= 1'b0;
		rst_sync_n <= 1'b0;
	end else begin
		rst_meta_n <= 1'b1;
		rst_sync_n <= rst_meta_n;
	end
end
// ----------------------------------------------------------------
// Input swap and buffer
// ----------------------------------------------------------------
wire [31:0] bit_rev;
genvar gb;
generate
	for (gb = 0; gb < 32; gb = gb + 1) begin : g_rev
		assign bit_rev[gb] = data_in[31 - gb];
	end
endgenerate
reg [31:0] swapped;
always @* begin
	case (swap_sel)
		`MDE_SWAP_WORD: swapped = data_in;
		`MDE_SWAP_HALF: swapped = {data_in[15:0], data_in[31:16]};
		`MDE_SWAP_BYTE: swapped = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
		default: swapped = bit_rev;
	endcase
end
reg [31:0]  fifo_mem [0:15];
reg [511:0] fifo_flat;
integer     fj;
always @* begin
	fifo_flat = 512'h0;
	for (fj = 0; fj < 16; fj = fj + 1) begin
		fifo_flat[32 * fj +: 32] = fifo_mem[fj];
	end
end
// Whole blocks leave at once, so the buffer always refills from slot 0
wire fifo_full = (fifo_level == `MDE_FIFO_DEPTH);
wire push      = data_write && !fifo_full && !digest_init;
wire start     = fifo_full && !busy && !digest_init;

always @(posedge clock) begin
	if (push) begin
		fifo_mem[fifo_level[3:0]] <= swapped;
	end
end
reg [4:0] next_level;
always @* begin
	if (digest_init || start) begin
		next_level = 5'h00;
	end else if (push) begin
		next_level = fifo_level + 5'h01;
	end else begin
		next_level = fifo_level;
	end
end
// ----------------------------------------------------------------
// Hash core
// ----------------------------------------------------------------
reg [6:0]   cnt;
reg         blk_md5;
reg         blk_final;
reg         final_pend;
reg         hmac_pass;
reg         restart;
reg [159:0] st;
reg [159:0] cv;
reg [511:0] wv;
// Two rounds per cycle is the least that fits 80 rounds into the budget
wire [6:0]   t0     = {cnt[5:0], 1'b0};
wire [6:0]   t1     = {cnt[5:0], 1'b1};
wire [31:0]  w0     = blk_md5 ? word_at(wv, md5_g(t0)) : sha_w(wv, t0);
wire [159:0] st1    = rnd(st, t0, blk_md5, w0);
wire [31:0]  w1     = blk_md5 ? word_at(wv, md5_g(t1)) : sha_w(wv, t1);
wire [159:0] st2    = rnd(st1, t1, blk_md5, w1);
wire [6:0]   pairs  = blk_md5 ? `MDE_MD5_ROUND_PAIRS : `MDE_SHA1_ROUND_PAIRS;
wire [6:0]   last   = (blk_md5 ? `MDE_MD5_BLOCK_CYCLES : `MDE_SHA1_BLOCK_CYCLES) - 7'h01;
wire         do_rnd = busy && (cnt < pairs);
wire         fold   = busy && (cnt == last);
wire [2:0]   slot   = `MDE_DIGEST_LAST_INDEX - load_index;
wire [159:0] chain  = restart ? `MDE_IV : digest_words;
wire         outer  = hmac_mode && !hmac_pass;
wire [159:0] fold_sum = {cv[159:128] + st[159:128], cv[127:96] + st[127:96],
	cv[95:64] + st[95:64], cv[63:32] + st[63:32],
	blk_md5 ? cv[31:0] : cv[31:0] + st[31:0]};
// Flags: a set in the same cycle as a clear wins
wire ir_next = start || digest_init || (input_ready_flag && !clear_input_ready);
wire dd_set  = fold && blk_final && !outer;
wire dd_next = dd_set || (digest_done_flag && !clear_digest_done);
always @(posedge clock or negedge rst_sync_n) begin
	if (!rst_sync_n) begin
		digest_words     <= `MDE_IV;
		fifo_level       <= 5'h00;
		input_ready_flag <= 1'b0;
		busy             <= 1'b0;
		dma_active_flag  <= 1'b0;
		digest_done_flag <= 1'b0;
		dma_req          <= 1'b0;
		irq              <= 1'b0;
		cnt              <= 7'h00;
		blk_md5          <= 1'b0;
		blk_final        <= 1'b0;
		final_pend       <= 1'b0;
		hmac_pass        <= 1'b0;
		restart          <= 1'b0;
		st               <= 160'h0;
		cv               <= 160'h0;
		wv               <= 512'h0;
	end else begin
		fifo_level       <= next_level;
		input_ready_flag <= ir_next;
		digest_done_flag <= dd_next;
		dma_active_flag  <= dma_enable && (next_level != 5'h00 || busy);
		dma_req          <= dma_enable && (next_level != `MDE_FIFO_DEPTH);
		irq <= (ir_next && input_ready_irq_mask) || (dd_next && digest_done_irq_mask);
		if (last_block) begin
			final_pend <= 1'b1;
		end
		if (busy) begin
			cnt <= cnt + 7'h01;
		end
		if (do_rnd) begin
			st <= st2;
			if (!blk_md5) begin
				wv[{t0[3:0], 5'h00} +: 32] <= w0;
				wv[{t1[3:0], 5'h00} +: 32] <= w1;
			end
		end
		if (digest_init) begin
			digest_words <= `MDE_IV;
			busy         <= 1'b0;
			final_pend   <= 1'b0;
			hmac_pass    <= 1'b0;
			restart      <= 1'b0;
		end else if (start) begin
			busy       <= 1'b1;
			cnt        <= 7'h00;
			blk_md5    <= algo_md5;
			blk_final  <= final_pend || last_block;
			final_pend <= 1'b0;
			wv         <= fifo_flat;
			cv         <= chain;
			st         <= chain;
			restart    <= 1'b0;
		end else if (fold) begin
			busy         <= 1'b0;
			digest_words <= fold_sum;
			if (blk_final) begin
				hmac_pass <= outer;
				restart   <= outer;
			end
		end else if (load_write && !busy && load_index <= `MDE_DIGEST_LAST_INDEX) begin
			digest_words[{slot, 5'h00} +: 32] <= load_data;
		end
	end
end
endmodule // mde_top
`default_nettype wire

//--- sim/mde_sva.sv
// Port checker for the message digest engine
`timescale 1ns/1ps
`default_nettype none
module mde_sva (
	input wire logic         clock,
	input wire logic         arst_n,
	input wire logic         algo_md5,
	input wire logic         digest_init,
	input wire logic         data_write,
	input wire logic         dma_enable,
	input wire logic         input_ready_irq_mask,
	input wire logic         digest_done_irq_mask,
	input wire logic         clear_digest_done,
	input wire logic [159:0] digest_words,
	input wire logic [4:0]   fifo_level,
	input wire logic         input_ready_flag,
	input wire logic         busy,
	input wire logic         digest_done_flag,
	input wire logic         dma_req,
	input wire logic         irq
);
	// ----
	// Busy length counter, algorithm latched at block start
	// ----
	reg  [6:0] bcnt;
	reg        md5_l;
	wire       start = (fifo_level == 5'h10) && !busy && !digest_init;
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bcnt  <= 7'h00;
			md5_l <= 1'b0;
		end else begin
			bcnt <= busy ? bcnt + 7'h01 : 7'h00;
			if (start)
				md5_l <= algo_md5;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Aborted blocks end early, so they are left out
	AST_SHA1_TIME: assert property ($fell(busy) && !$past(digest_init) && !md5_l |-> bcnt == 7'h42)
		else $error("sha1 block length wrong");
	AST_MD5_TIME: assert property ($fell(busy) && !$past(digest_init) && md5_l |-> bcnt == 7'h32)
		else $error("md5 block length wrong");
	AST_DIGEST_STILL: assert property (busy && $past(busy) |-> $stable(digest_words))
		else $error("digest moved while busy");
	AST_FIFO_CAP: assert property (fifo_level <= 5'h10)
		else $error("fifo level above depth");
	AST_FIFO_INC: assert property (data_write && fifo_level != 5'h10 && !digest_init |=> fifo_level == $past(fifo_level) + 5'h01)
		else $error("write not counted");
	AST_DMA_REQ: assert property ($past(arst_n) |-> dma_req == ($past(dma_enable) && fifo_level != 5'h10))
		else $error("dma request wrong");
	AST_IRQ: assert property ($past(arst_n) |-> irq == ((input_ready_flag && $past(input_ready_irq_mask)) || (digest_done_flag && $past(digest_done_irq_mask))))
		else $error("interrupt wrong");
	AST_START: assert property (start |=> busy && fifo_level == 5'h00 && input_ready_flag)
		else $error("block start wrong");
	AST_DONE_STICKY: assert property (digest_done_flag && !clear_digest_done && !digest_init |=> digest_done_flag)
		else $error("done flag lost");
	COV_SHA1: cover property ($fell(busy) && !md5_l);
	COV_MD5: cover property ($fell(busy) && md5_l);
	COV_IRQ: cover property (irq);
endmodule // mde_sva
bind mde_top mde_sva i_mde_sva (.*);
`default_nettype wire

//--- sim/mde_dma_model.sv
// Flow-controlled DMA writer standing in for the system bus master
`timescale 1ns/1ps
`default_nettype none
module mde_dma_model (
	input  wire logic        clock,
	input  wire logic        go,
	input  wire logic        stall,
	input  wire logic        dma_req,
	output var  logic        dma_write,
	output var  logic [31:0] dma_data,
	output var  logic [15:0] n_wr
);
	logic tog = 1'b0;
	initial begin
		dma_write = 1'b0;
		dma_data  = 32'h0000_0000;
		n_wr      = 16'h0000;
	end
	// Stall skips every other cycle; idle data is scrambled, not held
	always @(negedge clock) begin
		tog <= ~tog;
		if (go && dma_req && !(stall && tog)) begin
			dma_write <= 1'b1;
			dma_data  <= {16'ha5c3, n_wr};
			n_wr      <= n_wr + 16'h0001;
		end else begin
			dma_write <= 1'b0;
			dma_data  <= ~dma_data;
		end
	end
endmodule // mde_dma_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the message digest engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic         md5;
		logic [1:0]   sw;
		logic [31:0]  w0;
		logic [31:0]  wl;
		logic [159:0] h;
	} mde_row_t;
	localparam logic [159:0] IV = 160'h6745_2301_efcd_ab89_98ba_dcfe_1032_5476_c3d2_e1f0;
	localparam logic [159:0] SHA = 160'ha999_3e36_4706_816a_ba3e_2571_7850_c26c_9cd0_d89d;
	localparam logic [159:0] MD5 = 160'h9850_0190_b04f_d23c_7d3f_96d6_727f_e128_c3d2_e1f0;
	mde_row_t     rows [6];
	logic         clock, arst_n, md5, hmac, init, tb_wr, last, ldw, dma_en;
	logic         m_in, m_dn, clr_in, clr_dn, go, stall;
	logic [1:0]   sw;
	logic [2:0]   li;
	logic [31:0]  tb_d, ld;
	wire  [159:0] dig;
	wire  [4:0]   lvl;
	wire          rdy, busy, dact, done, dreq, irq, dwr;
	wire  [31:0]  dd;
	wire  [15:0]  n_wr;
	integer       failures, n_compared, k, r;
	mde_top i_mde_top (.clock(clock), .arst_n(arst_n), .algo_md5(md5), .hmac_mode(hmac),
		.swap_sel(sw), .digest_init(init), .data_in(dwr ? dd : tb_d), .data_write(tb_wr | dwr),
		.last_block(last), .load_write(ldw), .load_index(li), .load_data(ld), .dma_enable(dma_en),
		.input_ready_irq_mask(m_in), .digest_done_irq_mask(m_dn), .clear_input_ready(clr_in),
		.clear_digest_done(clr_dn), .digest_words(dig), .fifo_level(lvl), .input_ready_flag(rdy),
		.busy(busy), .dma_active_flag(dact), .digest_done_flag(done), .dma_req(dreq), .irq(irq));
	mde_dma_model i_mde_dma_model (.clock(clock), .go(go), .stall(stall), .dma_req(dreq),
		.dma_write(dwr), .dma_data(dd), .n_wr(n_wr));
	initial clock = 1'b0;
	always #12.5 clock = ~clock;
	// ----
	// Helpers
	// ----
	task tick(input integer n);
		repeat (n) @(negedge clock);
	endtask
	task chk(input logic [191:0] g, input logic [191:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One padded block, optionally aborted by init once running
	task blk(input mde_row_t x, input logic ab);
		integer i;
		md5 = x.md5;
		sw = x.sw;
		for (i = 0; i < 16; i++) begin
			@(negedge clock);
			tb_wr = 1'b1;
			tb_d = (i == 0) ? x.w0 : (i == (x.md5 ? 14 : 15)) ? x.wl : 32'h0000_0000;
		end
		@(negedge clock);
		tb_wr = 1'b0;
		tb_d = ~tb_d;
		tick(2);
		init = ab;
		tick(1);
		init = 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 100) begin
			tick(1);
			k++;
		end
	endtask
	task start_msg;
		init = 1'b1;
		tick(1);
		init = 1'b0;
		last = 1'b1;
		tick(1);
		last = 1'b0;
	endtask
	initial begin
		#(25.0 * 8000);
		failures++;
		finish_test;
	end
	// ----
	// Sequence
	// ----
	initial begin
		{arst_n, md5, hmac, init, tb_wr, last, ldw, dma_en, m_in, m_dn, clr_in, clr_dn} = 0;
		{go, stall, sw, li, tb_d, ld} = 0;
		failures = 0;
		n_compared = 0;
		rows[0] = '{1'b0, 2'h0, 32'h6162_6380, 32'h0000_0018, SHA};
		rows[1] = '{1'b1, 2'h0, 32'h8063_6261, 32'h0000_0018, MD5};
		rows[2] = '{1'b1, 2'h1, 32'h6261_8063, 32'h0018_0000, MD5};
		rows[3] = '{1'b1, 2'h2, 32'h6162_6380, 32'h1800_0000, MD5};
		rows[4] = '{1'b1, 2'h3, 32'h8646_c601, 32'h1800_0000, MD5};
		rows[5] = '{1'b0, 2'h2, 32'h8063_6261, 32'h1800_0000, SHA};
		tick(20);
		arst_n = 1'b1;
		tick(3);
		for (r = 0; r < 6; r++) begin
			start_msg;
			blk(rows[r], 1'b0);
			chk(dig, rows[r].h);
			chk(done, 1'b1);
			chk(k, rows[r].md5 ? 48 : 64);
			clr_dn = 1'b1;
			tick(1);
			clr_dn = 1'b0;
			$display("row %0d done", r);
		end
		hmac = 1'b1;
		start_msg;
		blk(rows[0], 1'b0);
		chk({dig, done}, {SHA, 1'b0});
		last = 1'b1;
		tick(1);
		last = 1'b0;
		blk(rows[0], 1'b0);
		chk({dig, done}, {SHA, 1'b1});
		m_dn = 1'b1;
		tick(2);
		chk(irq, 1'b1);
		{hmac, m_dn, clr_dn} = 3'h1;
		m_in = 1'b1;
		tick(2);
		chk(irq, 1'b1);
		{clr_dn, clr_in} = 2'h1;
		tick(1);
		clr_in = 1'b0;
		tick(1);
		chk({rdy, irq}, 2'h0);
		m_in = 1'b0;
		$display("keyed and irq done");
		blk(rows[1], 1'b1);
		chk({dig, busy, lvl}, {IV, 6'h00});
		ldw = 1'b1;
		for (r = 0; r < 6; r++) begin
			li = r[2:0];
			ld = {8{r[3:0]}};
			tick(1);
		end
		ldw = 1'b0;
		tick(1);
		chk(dig, 160'h0000_0000_1111_1111_2222_2222_3333_3333_4444_4444);
		$display("abort and load done");
		start_msg;
		{dma_en, go, stall} = 3'h7;
		tick(400);
		chk(dact, 1'b1);
		go = 1'b0;
		tick(120);
		chk(lvl, n_wr[3:0]);
		dma_en = 1'b0;
		tick(2);
		chk(dreq, 1'b0);
		$display("dma done");
		arst_n = 1'b0;
		tick(2);
		chk({dig, lvl, rdy, busy, dact, done, dreq, irq}, {IV, 11'h000});
		arst_n = 1'b1;
		tick(3);
		$display("reset done");
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
